// ### hdl/standby_failsafe_supervisor.sv
`timescale 1ns/1ps
module standby_failsafe_supervisor #(
   parameter int     NUM_PWM         = 3,
   parameter int     NUM_TREE_PINS   = 8,
   parameter int     THERMAL_PIN_TIMER_W   = 16,
   parameter longint FAILSAFE_CYCLES = failsafe_pkg::FAILSAFE_CYCLES
) (
   input  wire logic                     sys_clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     reg_wr_en_in,
   input  wire logic                     reg_rd_en_in,
   input  wire logic [7:0]               reg_addr_in,
   input  wire logic [7:0]               reg_wdata_in,
   output logic [7:0]                    reg_rdata_out,
   input  wire logic                     smbus_addressed_in,
   input  wire logic                     standby_supply_in,
   input  wire logic [7:0]               core_voltage_input_in,
   input  wire logic                     core_voltage_valid_in,
   input  wire logic [7:0]               core_low_limit_in,
   input  wire logic                     core_alert_enable_in,
   input  wire logic                     core_flag_clear_in,
   input  wire logic                     thermal_pin_n_in,
   input  wire logic                     shutdown_req_in,
   input  wire logic [NUM_PWM-1:0]       pwm_duty_in,
   input  wire logic [NUM_PWM-1:0]       drive_polarity_invert_in,
   input  wire logic [NUM_TREE_PINS-1:0] tree_pins_in,
   output logic                          core_flag_out,
   output logic                          alert_n_out,
   output logic                          core_low_out,
   output logic [THERMAL_PIN_TIMER_W-1:0]      thermal_timer_out,
   output logic                          adaptive_enable_out,
   output logic                          shutdown_out,
   output logic [NUM_PWM-1:0]            pwm_out,
   output logic                          fans_full_out,
   output logic                          load_defaults_out,
   output logic                          tree_test_active_out,
   output logic                          tree_out
);

   localparam int CNT_W = $clog2(FAILSAFE_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FAILSAFE_CYCLES - 1);

   logic [7:0]                    adaptive_ctrl_ff;
   logic [7:0]                    tree_test_ff;
   logic                          core_low_ff;
   logic                          core_flag_ff;
   logic                          alert_n_ff;
   logic [THERMAL_PIN_TIMER_W-1:0]      thermal_pin_timer_ff;
   logic                          adaptive_en_ff;
   logic                          shutdown_ff;
   logic [NUM_PWM-1:0]            pwm_ff;
   logic                          fans_full_ff;
   logic                          load_defaults_ff;
   logic [7:0]                    rdata_ff;
   logic [CNT_W-1:0]              fs_cnt_ff;
   failsafe_pkg::failsafe_state_t state_ff;
   failsafe_pkg::failsafe_state_t nxt_state;
   logic                          core_low_event;
   logic                          expiry_load;

   assign core_low_event = core_voltage_valid_in & standby_supply_in
                         & adaptive_ctrl_ff[failsafe_pkg::CORE_LOW_STANDBY_ENABLE_BIT]
                         & (core_voltage_input_in < core_low_limit_in);
   assign expiry_load = (state_ff == failsafe_pkg::ST_FULL_SPEED) & smbus_addressed_in;

   // Registers; a default load after expiry returns them to reset values
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         adaptive_ctrl_ff <= failsafe_pkg::ADAPTIVE_THRESHOLD_CONTROL_ONE_RST;
         tree_test_ff     <= failsafe_pkg::PIN_TREE_TEST_ENABLE_RST;
      end else if (expiry_load) begin
         adaptive_ctrl_ff <= failsafe_pkg::ADAPTIVE_THRESHOLD_CONTROL_ONE_RST;
         tree_test_ff     <= failsafe_pkg::PIN_TREE_TEST_ENABLE_RST;
      end else if (reg_wr_en_in) begin
         if (reg_addr_in == failsafe_pkg::ADAPTIVE_THRESHOLD_CONTROL_ONE_ADDR) begin
            adaptive_ctrl_ff <= reg_wdata_in;
         end
         if (reg_addr_in == failsafe_pkg::PIN_TREE_TEST_ENABLE_ADDR) begin
            tree_test_ff <= reg_wdata_in;
         end
      end
   end

   // Unmapped offsets read as zero
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd_en_in) begin
         case (reg_addr_in)
            failsafe_pkg::ADAPTIVE_THRESHOLD_CONTROL_ONE_ADDR: rdata_ff <= adaptive_ctrl_ff;
            failsafe_pkg::PIN_TREE_TEST_ENABLE_ADDR:           rdata_ff <= tree_test_ff;
            default:                                           rdata_ff <= 8'h00;
         endcase
      end
   end

   // Condition only changes on a finished measurement, never between samples
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         core_low_ff <= 1'b0;
      end else if (core_voltage_valid_in) begin
         core_low_ff <= core_low_event;
      end
   end

   // Set wins over a clear arriving in the same cycle
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         core_flag_ff <= 1'b0;
      end else if (core_low_event) begin
         core_flag_ff <= 1'b1;
      end else if (core_flag_clear_in) begin
         core_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         alert_n_ff <= 1'b1;
      end else begin
         alert_n_ff <= ~(core_flag_ff & core_alert_enable_in);
      end
   end

   // Timer saturates rather than wrapping so a long assertion is not lost
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         thermal_pin_timer_ff <= '0;
      end else if (!core_low_ff && !thermal_pin_n_in && !(&thermal_pin_timer_ff)) begin
         thermal_pin_timer_ff <= thermal_pin_timer_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         adaptive_en_ff <= 1'b1;
         shutdown_ff    <= 1'b0;
      end else begin
         adaptive_en_ff <= ~core_low_ff;
         shutdown_ff    <= shutdown_req_in & ~core_low_ff;
      end
   end

   // Power-on fail-safe sequencing
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         failsafe_pkg::ST_WAIT_RAIL: begin
            if (smbus_addressed_in) begin
               nxt_state = failsafe_pkg::ST_NORMAL;
            end else if (core_voltage_valid_in && core_voltage_input_in >= failsafe_pkg::CORE_RAIL_UP_CODE) begin
               nxt_state = failsafe_pkg::ST_COUNTING;
            end
         end
         failsafe_pkg::ST_COUNTING: begin
            if (smbus_addressed_in) begin
               nxt_state = failsafe_pkg::ST_NORMAL;
            end else if (fs_cnt_ff == CNT_LAST) begin
               nxt_state = failsafe_pkg::ST_FULL_SPEED;
            end
         end
         failsafe_pkg::ST_FULL_SPEED: begin
            if (smbus_addressed_in) begin
               nxt_state = failsafe_pkg::ST_NORMAL;
            end
         end
         failsafe_pkg::ST_NORMAL: nxt_state = failsafe_pkg::ST_NORMAL;
         default:                 nxt_state = failsafe_pkg::ST_WAIT_RAIL;
      endcase
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_ff <= failsafe_pkg::ST_WAIT_RAIL;
      end else begin
         state_ff <= nxt_state;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fs_cnt_ff <= '0;
      end else if (state_ff == failsafe_pkg::ST_COUNTING) begin
         fs_cnt_ff <= fs_cnt_ff + 1'b1;
      end else begin
         fs_cnt_ff <= '0;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         fans_full_ff     <= 1'b0;
         load_defaults_ff <= 1'b0;
      end else begin
         fans_full_ff     <= (nxt_state == failsafe_pkg::ST_FULL_SPEED);
         load_defaults_ff <= expiry_load;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PWM; p++) begin : g_pwm
         always_ff @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               pwm_ff[p] <= 1'b0;
            end else if (nxt_state == failsafe_pkg::ST_FULL_SPEED) begin
               pwm_ff[p] <= ~drive_polarity_invert_in[p];
            end else begin
               pwm_ff[p] <= pwm_duty_in[p];
            end
         end
      end
   endgenerate

   xnor_chain #(
      .NUM_PINS (NUM_TREE_PINS)
   ) u_tree (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .enable_in  (tree_test_ff[failsafe_pkg::TREE_TEST_ENABLE_BIT]),
      .pins_in    (tree_pins_in),
      .tree_out   (tree_out)
   );

   assign reg_rdata_out        = rdata_ff;
   assign core_flag_out        = core_flag_ff;
   assign alert_n_out          = alert_n_ff;
   assign core_low_out         = core_low_ff;
   assign thermal_timer_out    = thermal_pin_timer_ff;
   assign adaptive_enable_out  = adaptive_en_ff;
   assign shutdown_out         = shutdown_ff;
   assign pwm_out              = pwm_ff;
   assign fans_full_out        = fans_full_ff;
   assign load_defaults_out    = load_defaults_ff;
   assign tree_test_active_out = tree_test_ff[failsafe_pkg::TREE_TEST_ENABLE_BIT];

endmodule

// ### hdl/failsafe_pkg.sv
package failsafe_pkg;

   // Register map
   localparam logic [7:0] ADAPTIVE_THRESHOLD_CONTROL_ONE_ADDR = 8'h36;
   localparam logic [7:0] PIN_TREE_TEST_ENABLE_ADDR           = 8'h6F;

   // Field positions
   localparam int CORE_LOW_STANDBY_ENABLE_BIT = 1;
   localparam int TREE_TEST_ENABLE_BIT        = 0;

   // Values after reset and after a default load
   localparam logic [7:0] ADAPTIVE_THRESHOLD_CONTROL_ONE_RST = 8'h00;
   localparam logic [7:0] PIN_TREE_TEST_ENABLE_RST           = 8'h00;

   // Timing
   localparam longint CLK_HZ           = 100000000;
   localparam longint FAILSAFE_TIME_MS = 4600;
   localparam longint FAILSAFE_CYCLES  = (FAILSAFE_TIME_MS * CLK_HZ) / 1000;

   // Reading code at or above which the core rail counts as risen (0.75 V)
   localparam logic [7:0] CORE_RAIL_UP_CODE = 8'h40;

   typedef enum logic [1:0] {
      ST_WAIT_RAIL  = 2'b00,
      ST_COUNTING   = 2'b01,
      ST_FULL_SPEED = 2'b10,
      ST_NORMAL     = 2'b11
   } failsafe_state_t;

endpackage

// ### hdl/xnor_chain.sv
`timescale 1ns/1ps
module xnor_chain #(
   parameter int NUM_PINS = 8
) (
   input  wire logic                sys_clk_in,
   input  wire logic                rst_in,
   input  wire logic                enable_in,
   input  wire logic [NUM_PINS-1:0] pins_in,
   output logic                     tree_out
);

   logic [NUM_PINS-1:0] chain;
   logic                tree_ff;

   assign chain[0] = pins_in[0];

   genvar i;
   generate
      for (i = 1; i < NUM_PINS; i++) begin : g_link
         assign chain[i] = ~(chain[i-1] ^ pins_in[i]);
      end
   endgenerate

   // Output held low outside test mode so the tester sees a known level
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         tree_ff <= 1'b0;
      end else begin
         tree_ff <= enable_in & chain[NUM_PINS-1];
      end
   end

   assign tree_out = tree_ff;

endmodule

// ### sim/supervisor_checker.sv
`timescale 1ns/1ps
module supervisor_checker (
   input wire logic       sys_clk_in,
   input wire logic       rst_in,
   input wire logic       smbus_addressed_in,
   input wire logic       core_voltage_valid_in,
   input wire logic       core_alert_enable_in,
   input wire logic       shutdown_req_in,
   input wire logic [7:0] tree_pins_in,
   input wire logic       core_flag_out,
   input wire logic       alert_n_out,
   input wire logic       core_low_out,
   input wire logic       adaptive_enable_out,
   input wire logic       shutdown_out,
   input wire logic       fans_full_out,
   input wire logic       load_defaults_out,
   input wire logic       tree_test_active_out,
   input wire logic       tree_out
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   property p_flag; $rose(core_low_out) |-> core_flag_out; endproperty
   a_flag: assert property (p_flag) else $error("core flag not set");
   property p_alert; core_flag_out && core_alert_enable_in |=> !alert_n_out; endproperty
   a_alert: assert property (p_alert) else $error("alert missing");
   property p_quiet; !core_alert_enable_in |=> alert_n_out; endproperty
   a_quiet: assert property (p_quiet) else $error("alert while disabled");
   property p_adapt; core_low_out |=> !adaptive_enable_out; endproperty
   a_adapt: assert property (p_adapt) else $error("adaptive not held off");
   property p_shut; shutdown_out |-> $past(shutdown_req_in) && !$past(core_low_out); endproperty
   a_shut: assert property (p_shut) else $error("shutdown while core low");
   property p_back; !core_low_out |=> adaptive_enable_out; endproperty
   a_back: assert property (p_back) else $error("adaptive not restored");
   property p_tree; tree_test_active_out |=> tree_out == ~^$past(tree_pins_in); endproperty
   a_tree: assert property (p_tree) else $error("tree output wrong");
   property p_dflt; fans_full_out && smbus_addressed_in |=> !fans_full_out && load_defaults_out; endproperty
   a_dflt: assert property (p_dflt) else $error("no default load");
   property p_meas; $changed(core_low_out) |-> $past(core_voltage_valid_in); endproperty
   a_meas: assert property (p_meas) else $error("condition moved without sample");
endmodule
bind standby_failsafe_supervisor supervisor_checker i_supervisor_checker (.sys_clk_in, .rst_in,
   .smbus_addressed_in, .core_voltage_valid_in, .core_alert_enable_in, .shutdown_req_in, .tree_pins_in,
   .core_flag_out, .alert_n_out, .core_low_out, .adaptive_enable_out, .shutdown_out, .fans_full_out,
   .load_defaults_out, .tree_test_active_out, .tree_out);

// ### sim/rail_host_model.sv
`timescale 1ns/1ps
module rail_host_model (
   input  wire logic       sys_clk_in,
   output logic [7:0]      core_voltage_out,
   output logic            core_valid_out,
   output logic            addressed_out
);
   initial begin
      core_voltage_out = 8'h00;
      core_valid_out = 1'h0;
      addressed_out = 1'h0;
   end
   // Reading is only good with valid; inverted junk otherwise
   task automatic measure(input logic [7:0] v);
      core_voltage_out = v;
      core_valid_out = 1'h1;
      @(posedge sys_clk_in);
      #1;
      core_valid_out = 1'h0;
      core_voltage_out = ~v;
   endtask
   task automatic address;
      addressed_out = 1'h1;
      @(posedge sys_clk_in);
      #1;
      addressed_out = 1'h0;
   endtask
endmodule

// ### sim/standby_failsafe_supervisor_tb_top.sv
`timescale 1ns/1ps
module standby_failsafe_supervisor_tb_top;
   localparam int N = 20;
   logic sys_clk_in, rst_in, reg_wr_en_in, reg_rd_en_in, standby_supply_in, core_voltage_valid_in;
   logic core_alert_enable_in, core_flag_clear_in, thermal_pin_n_in, shutdown_req_in, smbus_addressed_in;
   logic core_flag_out, alert_n_out, core_low_out, adaptive_enable_out, shutdown_out, fans_full_out;
   logic load_defaults_out, tree_test_active_out, tree_out;
   logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, core_low_limit_in, core_voltage_input_in, tree_pins_in;
   logic [2:0] pwm_duty_in, drive_polarity_invert_in, pwm_out;
   logic [15:0] thermal_timer_out, t;
   int n_mismatch = 0;
   int checks = 0;
   rail_host_model i_rail_host_model (.sys_clk_in, .core_voltage_out(core_voltage_input_in),
      .core_valid_out(core_voltage_valid_in), .addressed_out(smbus_addressed_in));
   standby_failsafe_supervisor #(.FAILSAFE_CYCLES(N)) i_standby_failsafe_supervisor (.sys_clk_in, .rst_in,
      .reg_wr_en_in, .reg_rd_en_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .smbus_addressed_in,
      .standby_supply_in, .core_voltage_input_in, .core_voltage_valid_in, .core_low_limit_in,
      .core_alert_enable_in, .core_flag_clear_in, .thermal_pin_n_in, .shutdown_req_in, .pwm_duty_in,
      .drive_polarity_invert_in, .tree_pins_in, .core_flag_out, .alert_n_out, .core_low_out,
      .thermal_timer_out, .adaptive_enable_out, .shutdown_out, .pwm_out, .fans_full_out,
      .load_defaults_out, .tree_test_active_out, .tree_out);
   initial begin
      sys_clk_in = 1'h0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   task automatic tick;
      @(posedge sys_clk_in);
      #1;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr_in = a;
      reg_wdata_in = d;
      reg_wr_en_in = 1'h1;
      tick;
      reg_wr_en_in = 1'h0;
      // One idle edge keeps back-to-back calls from toggling the strobe in one step
      tick;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      reg_addr_in = a;
      reg_rd_en_in = 1'h1;
      tick;
      reg_rd_en_in = 1'h0;
      chk("register", e, reg_rdata_out);
      tick;
   endtask
   task automatic do_reset;
      rst_in = 1'h1;
      repeat (8) tick;
      rst_in = 1'h0;
   endtask
   task automatic results;
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Whole run is under 150 cycles; this margin only catches a hang
   initial begin
      repeat (5000) @(posedge sys_clk_in);
      n_mismatch++;
      results;
   end
   initial begin
      rst_in = 1'h1;
      {reg_wr_en_in, reg_rd_en_in, standby_supply_in, core_alert_enable_in, core_flag_clear_in} = 5'h00;
      {thermal_pin_n_in, shutdown_req_in} = 2'h1;
      {reg_addr_in, reg_wdata_in, core_low_limit_in, tree_pins_in} = 32'h0000_30A5;
      {pwm_duty_in, drive_polarity_invert_in} = 6'h1D;
      do_reset;
      rdc(8'h36, 8'h00);
      rdc(8'h6F, 8'h00);
      rdc(8'h55, 8'h00);
      wr(8'h36, 8'h02);
      rdc(8'h36, 8'h02);
      i_rail_host_model.measure(8'h40);
      repeat (N - 1) tick;
      chk("fans early", 1'h0, fans_full_out);
      tick;
      chk("fans full", 1'h1, fans_full_out);
      chk("pwm full", 3'h2, pwm_out);
      i_rail_host_model.address;
      chk("fans stop", 1'h0, fans_full_out);
      chk("defaults", 1'h1, load_defaults_out);
      chk("pwm duty", 3'h3, pwm_out);
      rdc(8'h36, 8'h00);
      standby_supply_in = 1'h1;
      core_alert_enable_in = 1'h1;
      i_rail_host_model.measure(8'h20);
      chk("low unarmed", 1'h0, core_low_out);
      wr(8'h36, 8'h02);
      i_rail_host_model.measure(8'h20);
      chk("low", 1'h1, core_low_out);
      chk("flag", 1'h1, core_flag_out);
      t = thermal_timer_out;
      tick;
      chk("alert", 1'h0, alert_n_out);
      chk("adaptive", 1'h0, adaptive_enable_out);
      chk("shutdown", 1'h0, shutdown_out);
      repeat (3) tick;
      chk("timer held", t, thermal_timer_out);
      i_rail_host_model.measure(8'h50);
      tick;
      chk("adaptive back", 1'h1, adaptive_enable_out);
      chk("shutdown back", 1'h1, shutdown_out);
      tick;
      chk("timer runs", 1'h1, 16'(thermal_timer_out !== t));
      chk("flag sticky", 1'h1, core_flag_out);
      thermal_pin_n_in = 1'h1;
      shutdown_req_in = 1'h0;
      tick;
      t = thermal_timer_out;
      tick;
      chk("timer idle", t, thermal_timer_out);
      chk("shutdown off", 1'h0, shutdown_out);
      core_flag_clear_in = 1'h1;
      tick;
      core_flag_clear_in = 1'h0;
      tick;
      chk("alert off", 1'h1, alert_n_out);
      wr(8'h6F, 8'h01);
      chk("tree on", 1'h1, tree_test_active_out);
      tick;
      chk("tree a5", 1'h1, tree_out);
      tree_pins_in = 8'h01;
      tick;
      chk("tree 01", 1'h0, tree_out);
      do_reset;
      i_rail_host_model.measure(8'h40);
      repeat (5) tick;
      i_rail_host_model.address;
      repeat (N + 5) tick;
      chk("cancelled", 1'h0, fans_full_out);
      do_reset;
      i_rail_host_model.measure(8'h10);
      repeat (N + 5) tick;
      chk("rail low", 1'h0, fans_full_out);
      results;
   end
endmodule
